// ### mcu_interrupt_wakeup_logic.sv
`timescale 1ns/10ps
`include "mcu_irq_defines.svh"

// Behaviour
// [RULE_01] Enabled counter wrap FF to 00 requests interrupt
// [RULE_02] Counter interrupt enable is active low
// [RULE_03] Overflow pending flag set, bit 7
// [RULE_04] Power down wake edge causes device reset
// [RULE_05] Normal mode wake edge requests interrupt
// [RULE_06] Eight pins, each with own enable
// [RULE_07] Per-pin rising or falling edge select
// [RULE_08] Per-pin pending flag set on edge
// [RULE_09] Both returns restore context and resume
// [RULE_10] Adjusting return adds accumulator to counter
// [RULE_11] Timer sources behave alike, own enables
// [RULE_12] Take saves context, disables, vectors zero
// [RULE_13] Latency three counter, five wakeup cycles
// [RULE_14] Pending at return retriggers immediately
// [RULE_15] Pending flags stay until software clears
module mcu_interrupt_wakeup_logic
(
   input  wire logic        sys_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        count_tick_in,
   input  wire logic        counter_wr_in,
   input  wire logic [7:0]  counter_wdata_in,
   input  wire logic        counter_irq_enable_n_in,
   input  wire logic        overflow_clear_in,
   input  wire logic [6:0]  timer1_ctrl_b_low_in,
   input  wire logic [7:0]  wake_pins_in,
   input  wire logic [7:0]  wake_pin_en_in,
   input  wire logic [7:0]  wake_irq_en_in,
   input  wire logic [7:0]  wake_edge_falling_in,
   input  wire logic [7:0]  wake_clear_in,
   input  wire logic        timer1_irq_in,
   input  wire logic        timer1_irq_en_in,
   input  wire logic        timer2_irq_in,
   input  wire logic        timer2_irq_en_in,
   input  wire logic        power_down_in,
   input  wire logic [11:0] pc_in,
   input  wire logic [7:0]  acc_in,
   input  wire logic [7:0]  status_in,
   input  wire logic [7:0]  file_select_pointer_in,
   input  wire logic        return_plain_in,
   input  wire logic        return_adjust_counter_in,
   output logic      [7:0]  counter_out,
   output logic             counter_overflow_pending_out,
   output logic      [7:0]  timer1_control_b_reg_out,
   output logic      [7:0]  wakeup_pending_flags_out,
   output logic             wake_reset_out,
   output logic             irq_take_out,
   output logic      [11:0] jump_addr_out,
   output logic             irq_disabled_out,
   output logic             restore_valid_out,
   output logic      [11:0] restore_pc_out,
   output logic      [7:0]  restore_acc_out,
   output logic      [7:0]  restore_status_out,
   output logic      [7:0]  restore_fsp_out
);

   // ==========================================================
   // Reset release synchroniser
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ==========================================================
   // Wakeup edge detector
   wake_edge_if wk ();

   assign wk.pins         = wake_pins_in;
   assign wk.pin_en       = wake_pin_en_in;
   assign wk.edge_falling = wake_edge_falling_in;
   assign wk.clear        = wake_clear_in;

   wake_edge_detect u_wake
   (
      .clk   (sys_clk_in),
      .rst_n (rst_n),
      .wk    (wk)
   );

   // ==========================================================
   // Sequencer signals
   mcu_irq_pkg::irq_state_e state;
   mcu_irq_pkg::irq_state_e next_state;
   logic [2:0]  wait_cnt;
   logic [7:0]  counter;
   logic        ovf_pending;
   logic [11:0] shadow_pc;
   logic [7:0]  shadow_acc;
   logic [7:0]  shadow_status;
   logic [7:0]  shadow_fsp;
   logic        restore_valid;
   logic        wake_reset;

   // Source decode
   wire rollover_w   = count_tick_in & (counter == `CNT_MAX);                          // [RULE_01]
   wire counter_req  = ovf_pending & ~counter_irq_enable_n_in;                         // [RULE_02]
   wire wake_req     = |(wk.pending & wake_irq_en_in);                                 // [RULE_05]
   wire timer_req    = (timer1_irq_in & timer1_irq_en_in) | (timer2_irq_in & timer2_irq_en_in); // [RULE_11]
   wire any_req      = ~power_down_in & (counter_req | wake_req | timer_req);          // [RULE_04]
   wire returning    = (state == mcu_irq_pkg::ST_SERVICE) & (return_plain_in | return_adjust_counter_in);
   wire adjusting    = (state == mcu_irq_pkg::ST_SERVICE) & return_adjust_counter_in;
   wire take_w       = (state == mcu_irq_pkg::ST_WAIT) & (wait_cnt == 3'h0);
   wire [2:0] lat_w  = (wake_req & ~counter_req & ~timer_req) ? `LAT_WAKE : `LAT_COUNTER; // [RULE_13]
   wire [7:0] adj_w  = counter + acc_in + {7'h00, count_tick_in};                     // [RULE_10]
   wire wake_edge_w  = |wk.edge_evt;

   // ==========================================================
   // Next-state decode
   always_comb
   begin
      next_state = state;
      unique case (state)
         mcu_irq_pkg::ST_IDLE:
            if (any_req)
               next_state = mcu_irq_pkg::ST_WAIT; // [RULE_14]
         mcu_irq_pkg::ST_WAIT:
            if (take_w)
               next_state = mcu_irq_pkg::ST_SERVICE;
         mcu_irq_pkg::ST_SERVICE:
            if (returning)
               next_state = mcu_irq_pkg::ST_IDLE; // [RULE_09]
         default:
            next_state = mcu_irq_pkg::ST_IDLE;
      endcase
   end

   // State and latency count
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state    <= mcu_irq_pkg::ST_IDLE;
         wait_cnt <= 3'h0;
      end
      else
      begin
         state    <= next_state;
         wait_cnt <= (state == mcu_irq_pkg::ST_IDLE) ? lat_w - 3'h1 : wait_cnt - 3'h1; // [RULE_13]
      end
   end

   // ==========================================================
   // Free-running counter, written or adjusted on return
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
         counter <= `CNT_ZERO;
      else if (adjusting)
         counter <= adj_w; // [RULE_10]
      else if (counter_wr_in)
         counter <= counter_wdata_in;
      else if (count_tick_in)
         counter <= counter + 8'h01; // [RULE_01]
   end

   // Overflow pending, set wins over clear
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
         ovf_pending <= 1'b0;
      else if (rollover_w & ~adjusting & ~counter_wr_in)
         ovf_pending <= 1'b1; // [RULE_03]
      else if (overflow_clear_in)
         ovf_pending <= 1'b0; // [RULE_15]
   end

   // ==========================================================
   // Context shadows and restore strobe
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shadow_pc     <= `PC_RESET;
         shadow_acc    <= `BYTE_RESET;
         shadow_status <= `BYTE_RESET;
         shadow_fsp    <= `BYTE_RESET;
      end
      else if (take_w)
      begin
         shadow_pc     <= pc_in; // [RULE_12]
         shadow_acc    <= acc_in;
         shadow_status <= status_in;
         shadow_fsp    <= file_select_pointer_in;
      end
   end

   // Restore pulse and power-down wake reset pulse
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         restore_valid <= 1'b0;
         wake_reset    <= 1'b0;
      end
      else
      begin
         restore_valid <= returning; // [RULE_09]
         wake_reset    <= power_down_in & wake_edge_w; // [RULE_04]
      end
   end

   // ==========================================================
   // Outputs
   assign counter_out                  = counter;
   assign counter_overflow_pending_out = ovf_pending;
   assign timer1_control_b_reg_out     = {ovf_pending, timer1_ctrl_b_low_in}; // [RULE_03]
   assign wakeup_pending_flags_out     = wk.pending;
   assign wake_reset_out               = wake_reset;
   assign irq_take_out                 = take_w;
   assign jump_addr_out                = `VECTOR_ADDR; // [RULE_12]
   assign irq_disabled_out             = (state != mcu_irq_pkg::ST_IDLE); // [RULE_12]
   assign restore_valid_out            = restore_valid;
   assign restore_pc_out               = shadow_pc;
   assign restore_acc_out              = shadow_acc;
   assign restore_status_out           = shadow_status;
   assign restore_fsp_out              = shadow_fsp;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n);

   a_rollover_wraps : assert property (rollover_w && !adjusting && !counter_wr_in |=> counter == 8'h00 && ovf_pending)
      else $error("Rollover did not wrap or flag"); // [RULE_01] [RULE_03]
   a_enable_blocks : assert property (state == mcu_irq_pkg::ST_IDLE && counter_irq_enable_n_in && !wake_req && !timer_req
      |=> state == mcu_irq_pkg::ST_IDLE) else $error("Disabled counter raised request"); // [RULE_02]
   a_counter_latency : assert property (state == mcu_irq_pkg::ST_IDLE && any_req && lat_w == `LAT_COUNTER
      |-> ##3 irq_take_out) else $error("Counter latency wrong"); // [RULE_13]
   a_wake_latency : assert property (state == mcu_irq_pkg::ST_IDLE && any_req && lat_w == `LAT_WAKE
      |-> !irq_take_out[*5] ##1 irq_take_out) else $error("Wake latency wrong"); // [RULE_13]
   a_take_saves : assert property (irq_take_out |-> jump_addr_out == 12'h000 ##1
      (irq_disabled_out && restore_pc_out == $past(pc_in) && restore_acc_out == $past(acc_in)))
      else $error("Take did not save or vector"); // [RULE_12]
   a_return_restore : assert property (returning |=> restore_valid_out && !irq_disabled_out)
      else $error("Return did not restore"); // [RULE_09]
   a_adjust_adds : assert property (adjusting |=> counter_out == 8'($past(counter) + $past(acc_in)
      + {7'h00, $past(count_tick_in)})) else $error("Adjust did not add accumulator"); // [RULE_10]
   a_powerdown_wake : assert property (power_down_in && wake_edge_w |=> wake_reset_out)
      else $error("Wake edge in power down lost"); // [RULE_04]
   a_no_irq_asleep : assert property (power_down_in && state == mcu_irq_pkg::ST_IDLE
      |=> state == mcu_irq_pkg::ST_IDLE) else $error("Interrupt started in power down"); // [RULE_04] [RULE_05]
   a_retrigger : assert property (returning && !power_down_in && (counter_req || wake_req || timer_req)
      |=> ##1 state == mcu_irq_pkg::ST_WAIT) else $error("Pending request not retaken"); // [RULE_14]

endmodule

// ### mcu_irq_defines.svh
`ifndef MCU_IRQ_DEFINES_SVH
`define MCU_IRQ_DEFINES_SVH

// ==========================================================
// Free-running counter
`define CNT_MAX         8'hFF
`define CNT_ZERO        8'h00
`define OVF_FLAG_BIT    7

// ==========================================================
// Interrupt response latency, in instruction cycles (one clock each)
`define LAT_COUNTER     3'h3
`define LAT_WAKE        3'h5

// ==========================================================
// Vector and reset values
`define VECTOR_ADDR     12'h000
`define PC_RESET        12'h000
`define BYTE_RESET      8'h00

`endif

// ### mcu_irq_pkg.sv
package mcu_irq_pkg;

   // ==========================================================
   // Interrupt sequencer states, Gray coded along idle-wait-service
   typedef enum logic [1:0]
   {
      ST_IDLE    = 2'h0,
      ST_WAIT    = 2'h1,
      ST_SERVICE = 2'h3
   } irq_state_e;

   typedef logic [7:0] pin_vec_t;

endpackage

// ### wake_edge_if.sv
`timescale 1ns/10ps

// ==========================================================
// Wakeup pin configuration and pending flags between blocks
interface wake_edge_if;
   mcu_irq_pkg::pin_vec_t pins;
   mcu_irq_pkg::pin_vec_t pin_en;
   mcu_irq_pkg::pin_vec_t edge_falling;
   mcu_irq_pkg::pin_vec_t clear;
   mcu_irq_pkg::pin_vec_t pending;
   mcu_irq_pkg::pin_vec_t edge_evt;

   modport detector (input pins, pin_en, edge_falling, clear, output pending, edge_evt);
   modport ctrl     (output pins, pin_en, edge_falling, clear, input pending, edge_evt);
endinterface

// ### wake_edge_detect.sv
`timescale 1ns/10ps

module wake_edge_detect
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   wake_edge_if.detector    wk
);

   // ==========================================================
   // Per-pin edge sense and sticky pending flags
   mcu_irq_pkg::pin_vec_t prev;
   mcu_irq_pkg::pin_vec_t pending;

   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_pin
         wire rise_w = wk.pins[i] & ~prev[i];
         wire fall_w = ~wk.pins[i] & prev[i];
         // Selected edge on a pin configured for wakeup
         assign wk.edge_evt[i] = wk.pin_en[i] & (wk.edge_falling[i] ? fall_w : rise_w); // [RULE_06] [RULE_07]

         // Set wins over clear so no edge is lost
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               pending[i] <= 1'b0;
            else if (wk.edge_evt[i])
               pending[i] <= 1'b1; // [RULE_08] [RULE_14]
            else if (wk.clear[i])
               pending[i] <= 1'b0; // [RULE_15]
         end

         a_pending_sticky : assert property (@(posedge clk) disable iff (!rst_n)
            pending[i] && !wk.clear[i] |=> pending[i]) else $error("Pending flag lost"); // [RULE_15]
         a_edge_sets : assert property (@(posedge clk) disable iff (!rst_n)
            wk.edge_evt[i] |=> pending[i]) else $error("Edge did not set pending"); // [RULE_08]
      end
   endgenerate

   // Previous pin sample for edge sense
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev <= 8'h00;
      else
         prev <= wk.pins;
   end

   assign wk.pending = pending;

endmodule

// ### wake_source_model.sv
`timescale 1ns/10ps

// ==========================================================
// External edge sources on the eight wakeup pins
module wake_source_model
(
   input  wire logic       clk_in,
   input  wire logic [7:0] flip_in,
   output logic      [7:0] pins_out
);
   // Pins idle low at power up
   initial pins_out = 8'h00;

   // A pin flips just after the edge that sees its request, then holds
   always @(posedge clk_in)
   begin
      pins_out <= pins_out ^ flip_in;
   end
endmodule

// ### tb_mcu_interrupt_wakeup_logic.sv
`timescale 1ns/10ps

module tb_mcu_interrupt_wakeup_logic;
   logic        sys_clk_in, reset_n_in, count_tick_in, counter_wr_in, counter_irq_enable_n_in;
   logic        overflow_clear_in, timer1_irq_in, timer1_irq_en_in, timer2_irq_in, timer2_irq_en_in;
   logic        power_down_in, return_plain_in, return_adjust_counter_in;
   logic [6:0]  timer1_ctrl_b_low_in;
   logic [7:0]  counter_wdata_in, wake_pins_in, wake_pin_en_in, wake_irq_en_in, wake_edge_falling_in;
   logic [7:0]  wake_clear_in, acc_in, status_in, file_select_pointer_in, flip, counter_out;
   logic [7:0]  timer1_control_b_reg_out, wakeup_pending_flags_out;
   logic [7:0]  restore_acc_out, restore_status_out, restore_fsp_out;
   logic [11:0] pc_in, jump_addr_out, restore_pc_out;
   logic        counter_overflow_pending_out, wake_reset_out, irq_take_out, irq_disabled_out;
   logic        restore_valid_out;
   int          n_fail, total_checks, cycles;

   // ==========================================================
   // Clock, far side model and block under test
   initial
   begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   wake_source_model u_src (.clk_in(sys_clk_in), .flip_in(flip), .pins_out(wake_pins_in));

   mcu_interrupt_wakeup_logic u_dut (.sys_clk_in, .reset_n_in, .count_tick_in, .counter_wr_in,
      .counter_wdata_in, .counter_irq_enable_n_in, .overflow_clear_in, .timer1_ctrl_b_low_in,
      .wake_pins_in, .wake_pin_en_in, .wake_irq_en_in, .wake_edge_falling_in, .wake_clear_in,
      .timer1_irq_in, .timer1_irq_en_in, .timer2_irq_in, .timer2_irq_en_in, .power_down_in, .pc_in,
      .acc_in, .status_in, .file_select_pointer_in, .return_plain_in, .return_adjust_counter_in,
      .counter_out, .counter_overflow_pending_out, .timer1_control_b_reg_out, .wakeup_pending_flags_out,
      .wake_reset_out, .irq_take_out, .jump_addr_out, .irq_disabled_out, .restore_valid_out,
      .restore_pc_out, .restore_acc_out, .restore_status_out, .restore_fsp_out);

   // ==========================================================
   // Shared helpers
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t %s: saw %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic ed(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask

   // Settle after the edge before sampling
   task automatic st(input int n);
      ed(n);
      #10;
   endtask

   task automatic pin_flip(input int i);
      ed(1);
      flip <= 8'h01 << i;
      ed(1);
      flip <= 8'h00;
   endtask

   task automatic clr(input logic [7:0] m, input logic o);
      ed(1);
      wake_clear_in <= m;
      overflow_clear_in <= o;
      ed(1);
      wake_clear_in <= 8'h00;
      overflow_clear_in <= 1'b0;
   endtask

   task automatic take_after(input int lat);
      repeat (lat - 1)
      begin
         st(1);
         chk(irq_take_out, 1'b0, "early take");
      end
      st(1);
      chk(irq_take_out, 1'b1, "take");
      chk(jump_addr_out, 12'h000, "vector");
      chk(irq_disabled_out, 1'b1, "disabled in service");
   endtask

   task automatic wait_pend(input int i);
      for (int k = 0; k < 6 && wakeup_pending_flags_out[i] !== 1'b1; k++)
         st(1);
      chk(wakeup_pending_flags_out, 8'h01 << i, "pending pin");
   endtask

   task automatic ret(input logic adj, input logic [7:0] cnt);
      ed(1);
      return_plain_in <= ~adj;
      return_adjust_counter_in <= adj;
      {pc_in, status_in, file_select_pointer_in} <= 28'h5C0_3C_E7; // Live context moves, shadows must hold
      ed(1);
      return_plain_in <= 1'b0;
      return_adjust_counter_in <= 1'b0;
      {pc_in, status_in, file_select_pointer_in} <= 28'h3A5_C3_7E;
      #10;
      chk(restore_valid_out, 1'b1, "restore valid");
      chk(irq_disabled_out, 1'b0, "enabled after return");
      chk(restore_pc_out, 12'h3A5, "pc");
      chk(restore_acc_out, 8'h05, "acc");
      chk(restore_status_out, 8'hC3, "status");
      chk(restore_fsp_out, 8'h7E, "pointer");
      chk(counter_out, cnt, "counter after return");
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_counter(input logic en_n);
      ed(1);
      counter_irq_enable_n_in <= en_n;
      counter_wr_in <= 1'b1;
      counter_wdata_in <= 8'hFF;
      ed(1);
      counter_wr_in <= 1'b0;
      count_tick_in <= 1'b1;
      ed(1);
      count_tick_in <= 1'b0;
      #10;
      chk(counter_out, 8'h00, "wrap");
      chk(counter_overflow_pending_out, 1'b1, "overflow flag");
      chk(timer1_control_b_reg_out, 8'hDA, "flag at bit 7");
      if (en_n == 1'b0)
         take_after(3);
      else
         repeat (8)
         begin
            st(1);
            chk(irq_disabled_out, 1'b0, "masked rollover");
         end
      clr(8'h00, 1'b1);
      st(1);
      chk(counter_overflow_pending_out, 1'b0, "overflow cleared");
      if (en_n == 1'b0)
         ret(1'b1, 8'h05);
      $display("counter test done");
   endtask

   task automatic t_wake;
      for (int i = 0; i < 8; i++)
      begin
         pin_flip(i);
         if (i % 2 == 1)
         begin
            st(6);
            chk(wakeup_pending_flags_out, 8'h00, "wrong edge");
            pin_flip(i);
         end
         wait_pend(i);
         take_after(5);
         chk(wakeup_pending_flags_out, 8'h01 << i, "sticky");
         clr(8'h01 << i, 1'b0);
         ret(1'b0, 8'h05);
         if (i % 2 == 0)
         begin
            pin_flip(i);
            st(6);
            chk(wakeup_pending_flags_out, 8'h00, "wrong edge");
         end
      end
      $display("wakeup test done");
   endtask

   task automatic t_gate;
      ed(1);
      wake_pin_en_in <= 8'hFE;
      pin_flip(0);
      st(6);
      chk(wakeup_pending_flags_out, 8'h00, "pin not enabled");
      ed(1);
      wake_pin_en_in <= 8'hFF;
      wake_irq_en_in <= 8'hFE;
      pin_flip(0);
      pin_flip(0);
      wait_pend(0);
      repeat (8)
      begin
         st(1);
         chk(irq_disabled_out, 1'b0, "irq not enabled");
      end
      chk(wakeup_pending_flags_out, 8'h01, "held flag");
      clr(8'h01, 1'b0);
      wake_irq_en_in <= 8'hFF;
      $display("gate test done");
   endtask

   task automatic t_power_down;
      ed(1);
      power_down_in <= 1'b1;
      pin_flip(2);
      for (int k = 0; k < 6 && wake_reset_out !== 1'b1; k++)
         st(1);
      chk(wake_reset_out, 1'b1, "wake reset");
      st(1);
      chk(wake_reset_out, 1'b0, "wake reset pulse");
      chk(irq_disabled_out, 1'b0, "no irq in power down");
      clr(8'h04, 1'b0);
      pin_flip(2);
      power_down_in <= 1'b0;
      $display("power down test done");
   endtask

   task automatic t_timer(input logic which);
      ed(1);
      {timer2_irq_en_in, timer1_irq_en_in} <= which ? 2'b01 : 2'b10;
      {timer2_irq_in, timer1_irq_in} <= which ? 2'b10 : 2'b01;
      st(6);
      chk(irq_disabled_out, 1'b0, "timer masked");
      ed(1);
      {timer2_irq_en_in, timer1_irq_en_in} <= 2'b11;
      for (int k = 0; k < 8 && irq_take_out !== 1'b1; k++)
         st(1);
      chk(irq_take_out, 1'b1, "timer take");
      ed(1);
      {timer2_irq_in, timer1_irq_in} <= 2'b00;
      pin_flip(4);
      st(6);
      chk(wakeup_pending_flags_out, 8'h10, "edge in service");
      chk(irq_disabled_out, 1'b1, "one at a time");
      ret(1'b0, 8'h05);
      for (int k = 0; k < 10 && irq_take_out !== 1'b1; k++)
         st(1);
      chk(irq_take_out, 1'b1, "retrigger");
      clr(8'h10, 1'b0);
      ret(1'b0, 8'h05);
      pin_flip(4);
      $display("timer test done");
   endtask

   // ==========================================================
   // Verdict and hang guard
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Cycle ceiling well above the run length
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   // Main sequence
   initial
   begin
      {count_tick_in, counter_wr_in, overflow_clear_in, timer1_irq_in, timer2_irq_in, power_down_in,
       return_plain_in, return_adjust_counter_in, reset_n_in, counter_wdata_in, wake_clear_in, flip} = '0;
      {counter_irq_enable_n_in, timer1_irq_en_in, timer2_irq_en_in} = 3'b111;
      {wake_pin_en_in, wake_irq_en_in, wake_edge_falling_in} = 24'hFFFFAA;
      {pc_in, acc_in, status_in, file_select_pointer_in} = 36'h3A5_05_C3_7E;
      timer1_ctrl_b_low_in = 7'h5A;
      ed(3);
      reset_n_in <= 1'b1;
      st(3);
      chk(timer1_control_b_reg_out, 8'h5A, "reset control b");
      chk(wakeup_pending_flags_out, 8'h00, "reset flags");
      t_counter(1'b1);
      t_counter(1'b0);
      t_wake();
      t_gate();
      t_power_down();
      t_timer(1'b0);
      t_timer(1'b1);
      tally_and_finish();
   end
endmodule
